// file: inc/slmc_pkg.sv
// Shared constants and types for the sleep and idle mode controller
package slmc_pkg;

    // Core clock rate
    localparam int CLK_MHZ = 125;

    // Delay timer width
    localparam int TMR_W = 12;

    // CPU ready delay after any wake, in ns
    localparam int CPU_READY_NS = 2000;
    localparam logic [TMR_W-1:0] CPU_READY_CYC = TMR_W'((CPU_READY_NS * CLK_MHZ + 999) / 1000);

    // Fast internal oscillator settle time, in ns
    localparam int FAST_SETTLE_NS = 1000;
    localparam logic [TMR_W-1:0] FAST_SETTLE_CYC =
        TMR_W'((FAST_SETTLE_NS * CLK_MHZ + 999) / 1000);

    // Clock switch: cycles of old source plus worst case of new source
    localparam int SW_W = 4;
    localparam logic [SW_W-1:0] SWITCH_OLD_CYC = 4'h2;
    localparam logic [SW_W-1:0] SWITCH_NEW_CYC = 4'h4;
    localparam logic [SW_W-1:0] SWITCH_CYC     = SWITCH_OLD_CYC + SWITCH_NEW_CYC;

    // Clock source select encodings
    localparam logic [1:0] SEL_PRI     = 2'h0;
    localparam logic [1:0] SEL_SEC     = 2'h1;
    localparam int         SEL_INT_BIT = 1;

    typedef enum logic [2:0] {
        MODE_RST_HOLD,
        MODE_RUN,
        MODE_SLEEP,
        MODE_IDLE,
        MODE_WAKE
    } slmc_mode_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_PRI,
        SRC_SEC,
        SRC_INT
    } slmc_src_t;

    // Maps the source select bits to a clock source; low bit ignored for internal
    function automatic slmc_src_t slmc_sel_src(input logic [1:0] sel);
        slmc_src_t r;
        r = SRC_PRI;
        if (sel[SEL_INT_BIT]) begin
            r = SRC_INT;
        end else if (sel == SEL_SEC) begin
            r = SRC_SEC;
        end
        return r;
    endfunction : slmc_sel_src

endpackage : slmc_pkg

// file: design/slmc_timer.sv
// Loadable down counter used for wake and settle delays
`timescale 1ns/100ps
`default_nettype none

module slmc_timer
    import slmc_pkg::*;
#(
    parameter int W = TMR_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // Status
    output logic              done
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } slmc_tmr_t;

    slmc_tmr_t s;
    slmc_tmr_t next_s;

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.cnt = load;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = (s.cnt == '0);

endmodule : slmc_timer

`default_nettype wire

// file: design/slmc_ctrl.sv
// Sleep and idle power mode controller: clock gating, status flags, wake sequencing
// Functional notes
// - Sleep entry stops oscillator, clears all flags
// - Slow and secondary oscillators keep running when needed
// - Sleep wake waits for selected source ready
// - Wake never alters idle or source select
// - Idle entry gates CPU; keeps peripherals, flags unless the source changes
// - Idle exits only by interrupt, watchdog, reset
// - Watchdog timeout in low power wakes device
// - Primary idle keeps primary clock and ready flag
// - Secondary idle clears primary ready, sets secondary
// - Secondary idle ignored when secondary osc disabled
// - Peripheral clocks withheld until secondary osc runs
// - Secondary idle wake resumes on secondary oscillator
// - Internal idle on select high bit, primary off
// - Fast internal output enabled, stable after settle
// - Fast output off, stable clear when unrequested
// - Internal idle wake resumes on internal mux
// - Interrupt wake branches only with global enable
// - Watchdog timeout while running causes reset
// - Watchdog cleared on sleep, clear, fail, write
// - Reset exit held until primary clock ready
// - Two-speed start runs internal until primary ready
// - CPU ready delay overlaps other start-up waits
// - Clock switch takes two old, four new cycles
`timescale 1ns/100ps
`default_nettype none

module slmc_ctrl
    import slmc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // CPU requests and firmware bits
    input  wire logic       power_down_instr,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       idle_select,
    input  wire logic [1:0] clock_source_select,
    input  wire logic       secondary_osc_enable,
    input  wire logic [2:0] internal_freq_select,
    input  wire logic       internal_freq_write,
    input  wire logic       low_freq_source_select,
    input  wire logic       global_irq_enable,
    input  wire logic       irq_wake_request,
    // Configuration
    input  wire logic       watchdog_enable,
    input  wire logic       fail_safe_enable,
    input  wire logic       two_speed_enable,
    input  wire logic       primary_is_internal,
    // Events from same-clock logic
    input  wire logic       watchdog_timeout,
    input  wire logic       clock_fail,
    // Oscillator pins
    input  wire logic       primary_osc_ready_pin,
    input  wire logic       secondary_osc_running_pin,
    // Clock gating and oscillator control
    output logic            cpu_clk_en,
    output logic            periph_clk_en,
    output logic [1:0]      clk_source,
    output logic            primary_osc_en,
    output logic            secondary_osc_run,
    output logic            slow_osc_en,
    output logic            fast_osc_en,
    output logic            cpu_reset_hold,
    // Status flags
    output logic            primary_clock_ready,
    output logic            internal_fast_osc_stable,
    output logic            secondary_clock_active,
    // Event pulses
    output logic            watchdog_clear,
    output logic            watchdog_reset,
    output logic            irq_vector_branch,
    output logic            wake_done
);

    typedef struct packed {
        slmc_mode_t st;
        slmc_src_t  src;
        logic       by_irq;
        logic       prim_pend;
        logic [SW_W-1:0] sw_cnt;
        logic [2:0] prim_s;
        logic       prim_ok;
        logic [2:0] sec_s;
        logic       sec_ok;
        logic       pri_rdy;
        logic       int_stb;
        logic       sec_act;
        logic       settling;
        logic       cpu_clk_en;
        logic       periph_clk_en;
        logic       primary_osc_en;
        logic       fast_osc_en;
        logic       wdt_clear;
        logic       wdt_reset;
        logic       irq_branch;
        logic       wake_done;
    } slmc_state_t;

    slmc_state_t s;
    slmc_state_t next_s;
    logic        ready_start;
    logic        ready_done;
    logic        settle_start;
    logic        settle_done;
    logic        fast_req;
    logic        int_active;
    logic        two_speed;
    logic        wake_evt;
    logic        src_ready;
    slmc_src_t   tgt;

    slmc_timer #(.W(TMR_W)) u_ready (
        .clk   (clk),
        .rst   (rst),
        .start (ready_start),
        .load  (CPU_READY_CYC),
        .done  (ready_done)
    );

    slmc_timer #(.W(TMR_W)) u_settle (
        .clk   (clk),
        .rst   (rst),
        .start (settle_start),
        .load  (FAST_SETTLE_CYC),
        .done  (settle_done)
    );

    always_comb begin
        next_s       = s;
        ready_start  = 1'b0;
        settle_start = 1'b0;
        next_s.wdt_clear  = 1'b0;
        next_s.wdt_reset  = 1'b0;
        next_s.irq_branch = 1'b0;
        next_s.wake_done  = 1'b0;
        // Select bits are only read here, never written
        tgt        = slmc_sel_src(clock_source_select);
        fast_req   = (internal_freq_select != 3'h0) | low_freq_source_select;
        two_speed  = two_speed_enable | fail_safe_enable;
        wake_evt   = irq_wake_request | watchdog_timeout;
        int_active = (s.src == SRC_INT) && (s.st != MODE_SLEEP) && (s.st != MODE_RST_HOLD);
        src_ready  = (s.src == SRC_INT) || (s.src == SRC_PRI && s.prim_ok) ||
                     (s.src == SRC_SEC && s.sec_ok);

        // Pin synchronisers: change accepted when stages two and three agree
        next_s.prim_s = {s.prim_s[1:0], primary_osc_ready_pin};
        next_s.sec_s  = {s.sec_s[1:0], secondary_osc_running_pin};
        if (s.prim_s[1] == s.prim_s[2]) begin
            next_s.prim_ok = s.prim_s[2];
        end
        if (s.sec_s[1] == s.sec_s[2]) begin
            next_s.sec_ok = s.sec_s[2];
        end

        // Watchdog clears outside the power-down path
        if (watchdog_clear_instr || (clock_fail && fail_safe_enable) ||
            (internal_freq_write && int_active)) begin
            next_s.wdt_clear = 1'b1;
        end

        case (s.st)
            MODE_RST_HOLD: begin
                next_s.cpu_clk_en     = 1'b0;
                next_s.periph_clk_en  = 1'b0;
                next_s.primary_osc_en = 1'b1;
                if (two_speed) begin
                    // Execute from the internal block while the primary starts
                    next_s.st            = MODE_RUN;
                    next_s.src           = SRC_INT;
                    next_s.prim_pend     = 1'b1;
                    next_s.cpu_clk_en    = 1'b1;
                    next_s.periph_clk_en = 1'b1;
                end else if (s.prim_ok) begin
                    next_s.st            = MODE_RUN;
                    next_s.src           = SRC_PRI;
                    next_s.pri_rdy       = 1'b1;
                    next_s.cpu_clk_en    = 1'b1;
                    next_s.periph_clk_en = 1'b1;
                end
            end
            MODE_RUN: begin
                next_s.cpu_clk_en    = 1'b1;
                next_s.periph_clk_en = 1'b1;
                // A power-down in the same cycle keeps the flags as they stand
                if (s.prim_pend && s.prim_ok && !power_down_instr) begin
                    next_s.src       = SRC_PRI;
                    next_s.prim_pend = 1'b0;
                    next_s.pri_rdy   = 1'b1;
                end
                if (watchdog_timeout) begin
                    next_s.wdt_reset = 1'b1;
                end
                if (power_down_instr && !idle_select) begin
                    // Sleep needs no clock switch
                    next_s.st             = MODE_SLEEP;
                    next_s.src            = SRC_NONE;
                    next_s.prim_pend      = 1'b0;
                    next_s.cpu_clk_en     = 1'b0;
                    next_s.periph_clk_en  = 1'b0;
                    next_s.primary_osc_en = 1'b0;
                    next_s.pri_rdy        = 1'b0;
                    next_s.sec_act        = 1'b0;
                    next_s.wdt_clear      = 1'b1;
                end else if (power_down_instr && !(tgt == SRC_SEC && !secondary_osc_enable)) begin
                    // Ignored when secondary idle is chosen but its oscillator is off
                    next_s.st         = MODE_IDLE;
                    next_s.cpu_clk_en = 1'b0;
                    next_s.wdt_clear  = 1'b1;
                    next_s.src        = tgt;
                    if (tgt != s.src) begin
                        next_s.sw_cnt        = SWITCH_CYC;
                        next_s.periph_clk_en = 1'b0;
                    end
                    if (tgt == SRC_PRI) begin
                        // Firmware has cleared the select bits before sleeping
                        next_s.primary_osc_en = 1'b1;
                    end else begin
                        next_s.prim_pend      = 1'b0;
                        next_s.primary_osc_en = 1'b0;
                        next_s.pri_rdy        = 1'b0;
                        next_s.sec_act        = (tgt == SRC_SEC);
                    end
                end
            end
            MODE_IDLE: begin
                next_s.cpu_clk_en = 1'b0;
                if (s.sw_cnt != '0) begin
                    next_s.sw_cnt = s.sw_cnt - SW_W'(1);
                end
                // Secondary source must actually oscillate before peripherals run
                next_s.periph_clk_en = (s.sw_cnt == '0) &&
                                       (s.src != SRC_SEC || s.sec_ok);
                if (wake_evt) begin
                    next_s.st     = MODE_WAKE;
                    next_s.by_irq = irq_wake_request;
                    ready_start   = 1'b1;
                end
            end
            MODE_SLEEP: begin
                next_s.cpu_clk_en    = 1'b0;
                next_s.periph_clk_en = 1'b0;
                if (wake_evt) begin
                    // Wake into the run mode given by the select bits
                    next_s.st     = MODE_WAKE;
                    next_s.by_irq = irq_wake_request;
                    next_s.src    = tgt;
                    ready_start   = 1'b1;
                    if (tgt == SRC_PRI) begin
                        next_s.primary_osc_en = 1'b1;
                        if (two_speed) begin
                            next_s.src       = SRC_INT;
                            next_s.prim_pend = 1'b1;
                        end
                    end
                end
            end
            MODE_WAKE: begin
                next_s.cpu_clk_en = 1'b0;
                // Ready delay runs alongside the wait for the source
                if (ready_done && src_ready) begin
                    next_s.st            = MODE_RUN;
                    next_s.cpu_clk_en    = 1'b1;
                    next_s.periph_clk_en = 1'b1;
                    next_s.wake_done     = 1'b1;
                    next_s.irq_branch    = s.by_irq && global_irq_enable;
                    if (s.src == SRC_PRI) begin
                        next_s.pri_rdy = 1'b1;
                    end
                    if (s.src == SRC_SEC) begin
                        next_s.sec_act = 1'b1;
                    end
                end
            end
            default: begin
                next_s.st = MODE_RST_HOLD;
            end
        endcase

        // Fast internal output follows the request while the internal block clocks;
        // sleep entry stops it so the stable flag clears with the others
        next_s.fast_osc_en = int_active && fast_req && (next_s.st != MODE_SLEEP);
        if (!next_s.fast_osc_en) begin
            next_s.int_stb  = 1'b0;
            next_s.settling = 1'b0;
        end else if (!s.fast_osc_en) begin
            settle_start    = 1'b1;
            next_s.settling = 1'b1;
        end else if (s.settling && settle_done) begin
            next_s.int_stb  = 1'b1;
            next_s.settling = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s                <= '0;
            s.st             <= MODE_RST_HOLD;
            s.primary_osc_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign cpu_clk_en             = s.cpu_clk_en;
    assign periph_clk_en          = s.periph_clk_en;
    assign clk_source             = s.src;
    assign primary_osc_en         = s.primary_osc_en;
    assign secondary_osc_run      = secondary_osc_enable;
    assign slow_osc_en            = watchdog_enable || fail_safe_enable ||
                                    s.src == SRC_INT;
    assign fast_osc_en            = s.fast_osc_en;
    assign cpu_reset_hold         = (s.st == MODE_RST_HOLD);
    // An internal primary reports stability instead of primary ready
    assign primary_clock_ready    = s.pri_rdy && !primary_is_internal;
    assign internal_fast_osc_stable          = s.int_stb || (s.pri_rdy && primary_is_internal);
    assign secondary_clock_active = s.sec_act;
    assign watchdog_clear         = s.wdt_clear;
    assign watchdog_reset         = s.wdt_reset;
    assign irq_vector_branch      = s.irq_branch;
    assign wake_done              = s.wake_done;

    localparam int WAKE_MAX = 260;

    chk_sleep_flags: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_RUN && power_down_instr && !idle_select) |=>
        (!primary_clock_ready && !secondary_clock_active && !internal_fast_osc_stable && !primary_osc_en))
        else $error("sleep entry left a flag or oscillator on");
    chk_idle_cpu_off: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_RUN && power_down_instr && idle_select && tgt == SRC_PRI) |=>
        (!cpu_clk_en && $stable(primary_clock_ready)))
        else $error("primary idle entry did not gate cpu or changed flag");
    chk_sec_ignore: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_RUN && power_down_instr && idle_select && tgt == SRC_SEC &&
         !secondary_osc_enable) |=> (s.st == MODE_RUN && cpu_clk_en))
        else $error("secondary idle entered with oscillator disabled");
    chk_sec_hold: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_IDLE && s.src == SRC_SEC && !s.sec_ok) |=> !periph_clk_en)
        else $error("peripheral clock before secondary oscillator runs");
    chk_run_wdt: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_RUN && watchdog_timeout) |=> watchdog_reset)
        else $error("watchdog timeout in run gave no reset");
    chk_wdt_clear: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_RUN && power_down_instr && !idle_select) |=> watchdog_clear)
        else $error("power down did not clear watchdog");
    chk_ready_delay: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_IDLE && s.src == SRC_INT && wake_evt) |=>
        (!cpu_clk_en [*8] ##[1:WAKE_MAX] (s.st == MODE_RUN && cpu_clk_en && s.src == SRC_INT)))
        else $error("internal idle wake timing wrong");
    chk_branch: assert property (@(posedge clk) disable iff (rst)
        irq_vector_branch |-> ($past(global_irq_enable) && wake_done))
        else $error("vector branch without global enable");
    chk_fast_off: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_IDLE && s.src == SRC_INT && !fast_req) |=>
        (!fast_osc_en && !internal_fast_osc_stable))
        else $error("fast output on without request");
    chk_sec_entry: assert property (@(posedge clk) disable iff (rst)
        (s.st == MODE_RUN && power_down_instr && idle_select && tgt == SRC_SEC &&
         secondary_osc_enable) |=> (secondary_clock_active && !s.pri_rdy && !primary_osc_en))
        else $error("secondary idle entry flags wrong");

endmodule : slmc_ctrl

`default_nettype wire

// file: testbench/slmc_osc_model.sv
// Oscillator start-up model driving the ready and running pins
`timescale 1ns/100ps
`default_nettype none

module slmc_osc_model #(
    parameter int PRI_START = 20,
    parameter int SEC_START = 30
) (
    // Clock
    input  wire logic clk,
    // Oscillator enables
    input  wire logic pri_en,
    input  wire logic sec_en,
    // Oscillator status pins
    output logic      pri_ready,
    output logic      sec_running
);
    int pri_cnt = 0;
    int sec_cnt = 0;

    // Pins drop as soon as an oscillator is stopped
    always @(posedge clk) begin
        pri_cnt <= pri_en ? pri_cnt + 1 : 0;
        sec_cnt <= sec_en ? sec_cnt + 1 : 0;
    end

    assign pri_ready   = pri_en && (pri_cnt >= PRI_START);
    assign sec_running = sec_en && (sec_cnt >= SEC_START);
endmodule : slmc_osc_model

`default_nettype wire

// file: testbench/sleep_idle_mode_controller_test.sv
// Self-checking bench for the sleep and idle mode controller
`timescale 1ns/100ps
`default_nettype none

module sleep_idle_mode_controller_test;
    import slmc_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, power_down_instr = 1'b0, watchdog_clear_instr = 1'b0;
    logic       idle_select = 1'b0, secondary_osc_enable = 1'b0, internal_freq_write = 1'b0;
    logic [1:0] clock_source_select = 2'h0;
    logic [2:0] internal_freq_select = 3'h0;
    logic       low_freq_source_select = 1'b0, global_irq_enable = 1'b0, irq_wake_request = 1'b0;
    logic       watchdog_enable = 1'b1, fail_safe_enable = 1'b0, two_speed_enable = 1'b0;
    logic       primary_is_internal = 1'b0, watchdog_timeout = 1'b0, clock_fail = 1'b0;
    logic       primary_osc_ready_pin, secondary_osc_running_pin, cpu_clk_en, periph_clk_en;
    logic       primary_osc_en, secondary_osc_run, slow_osc_en, fast_osc_en, cpu_reset_hold;
    logic [1:0] clk_source;
    logic       primary_clock_ready, internal_fast_osc_stable, secondary_clock_active, branch;
    logic       watchdog_clear, watchdog_reset, irq_vector_branch, wake_done;
    int         bad_count = 0, tests_run = 0, cycles = 0, clears = 0, resets = 0, c0, wait_cyc;

    slmc_ctrl i_slmc_ctrl (.clk, .rst, .power_down_instr, .watchdog_clear_instr, .idle_select,
        .clock_source_select, .secondary_osc_enable, .internal_freq_select, .internal_freq_write,
        .low_freq_source_select, .global_irq_enable, .irq_wake_request, .watchdog_enable,
        .fail_safe_enable, .two_speed_enable, .primary_is_internal, .watchdog_timeout,
        .clock_fail, .primary_osc_ready_pin, .secondary_osc_running_pin, .cpu_clk_en,
        .periph_clk_en, .clk_source, .primary_osc_en, .secondary_osc_run, .slow_osc_en,
        .fast_osc_en, .cpu_reset_hold, .primary_clock_ready, .internal_fast_osc_stable,
        .secondary_clock_active, .watchdog_clear, .watchdog_reset, .irq_vector_branch, .wake_done);

    slmc_osc_model i_slmc_osc_model (.clk, .pri_en(primary_osc_en), .sec_en(secondary_osc_run),
        .pri_ready(primary_osc_ready_pin), .sec_running(secondary_osc_running_pin));

    always #4 clk = ~clk;

    // Counts event pulses and cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (watchdog_clear === 1'b1) clears++;
        if (watchdog_reset === 1'b1) resets++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Firmware order: idle bit first, then source select, then power-down
    task automatic enter(input logic idl, input logic [1:0] sl);
        idle_select = idl;
        tick(1);
        clock_source_select = sl;
        tick(1);
        power_down_instr = 1'b1;
        tick(1);
        power_down_instr = 1'b0;
        tick(2);
    endtask : enter

    task automatic wake(input logic by_irq);
        irq_wake_request = by_irq;
        watchdog_timeout = !by_irq;
        tick(1);
        irq_wake_request = 1'b0;
        watchdog_timeout = 1'b0;
        wait_cyc = 1;
        while (wake_done !== 1'b1 && wait_cyc < 2000) begin
            @(negedge clk);
            wait_cyc++;
        end
        branch = irq_vector_branch;
        tick(1);
    endtask : wake

    task automatic finish_test;
        $display("Checks run: %0d, mismatches: %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        tick(5);
        rst = 1'b0;
        chk(cpu_reset_hold, 1);
        wait_cyc = 0;
        while (cpu_clk_en !== 1'b1 && wait_cyc < 200) begin
            tick(1);
            wait_cyc++;
        end
        chk({cpu_reset_hold, primary_clock_ready, wait_cyc >= 10}, 3'h3);
        // Sleep, interrupt wake with vector branch
        c0 = clears;
        enter(1'b0, 2'h0);
        chk({cpu_clk_en, periph_clk_en, primary_osc_en}, 0);
        chk({primary_clock_ready, internal_fast_osc_stable, secondary_clock_active}, 0);
        chk(16'(clears - c0), 1);
        chk(slow_osc_en, 1);
        global_irq_enable = 1'b1;
        wake(1'b1);
        chk(wait_cyc >= CPU_READY_CYC && wait_cyc <= CPU_READY_CYC + 6, 1);
        chk({branch, primary_clock_ready, cpu_clk_en}, 3'h7);
        // Primary idle, watchdog wake
        enter(1'b1, 2'h0);
        chk({cpu_clk_en, periph_clk_en, primary_clock_ready, primary_osc_en}, 4'h7);
        c0 = resets;
        wake(1'b0);
        chk(wait_cyc >= CPU_READY_CYC && wait_cyc <= CPU_READY_CYC + 6, 1);
        chk({branch, primary_clock_ready, cpu_clk_en}, 3'h3);
        chk(16'(resets - c0), 0);
        // Watchdog time-out and clear while running
        watchdog_timeout = 1'b1;
        tick(1);
        watchdog_timeout = 1'b0;
        tick(1);
        chk(16'(resets - c0), 1);
        c0 = clears;
        watchdog_clear_instr = 1'b1;
        tick(1);
        watchdog_clear_instr = 1'b0;
        tick(1);
        chk(16'(clears - c0), 1);
        // Clock loss clears the watchdog only with fail-safe monitoring on
        c0 = clears;
        clock_fail = 1'b1;
        tick(1);
        fail_safe_enable = 1'b1;
        tick(1);
        clock_fail = 1'b0;
        fail_safe_enable = 1'b0;
        tick(1);
        chk(16'(clears - c0), 1);
        // Secondary idle refused while the oscillator is disabled
        c0 = clears;
        enter(1'b1, 2'h1);
        chk({cpu_clk_en, 16'(clears - c0) == 16'h0}, 2'h3);
        // Secondary idle with a late oscillator
        watchdog_enable = 1'b0;
        secondary_osc_enable = 1'b1;
        enter(1'b1, 2'h1);
        tick(10);
        chk(periph_clk_en, 0);
        tick(40);
        chk({periph_clk_en, secondary_clock_active, primary_clock_ready}, 3'h6);
        chk({primary_osc_en, secondary_osc_run, slow_osc_en}, 3'h2);
        global_irq_enable = 1'b0;
        wake(1'b1);
        chk({branch, cpu_clk_en, secondary_clock_active, clk_source}, 5'h0E);
        // Internal idle with fast output settling
        internal_freq_select = 3'h3;
        enter(1'b1, 2'h2);
        chk({primary_clock_ready, primary_osc_en}, 0);
        tick(10);
        chk({fast_osc_en, internal_fast_osc_stable}, 2'h2);
        tick(int'(FAST_SETTLE_CYC) + 10);
        chk({internal_fast_osc_stable, periph_clk_en, cpu_clk_en}, 3'h6);
        wake(1'b1);
        chk({cpu_clk_en, internal_fast_osc_stable, slow_osc_en, clk_source}, 5'h1F);
        c0 = clears;
        internal_freq_select = 3'h0;
        internal_freq_write = 1'b1;
        tick(1);
        internal_freq_write = 1'b0;
        tick(2);
        chk(16'(clears - c0), 1);
        chk({fast_osc_en, internal_fast_osc_stable}, 0);
        // Internal idle with no fast request, watchdog wake
        enter(1'b1, 2'h2);
        tick(10);
        chk({fast_osc_en, internal_fast_osc_stable, periph_clk_en, cpu_clk_en}, 4'h2);
        wake(1'b0);
        chk({branch, cpu_clk_en, clk_source}, 4'h7);
        // Mid-run reset with two-speed start-up
        rst = 1'b1;
        two_speed_enable = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        chk({cpu_reset_hold, cpu_clk_en, clk_source, primary_clock_ready}, 5'h0E);
        tick(40);
        chk({clk_source, primary_clock_ready, primary_osc_en}, 4'h7);
        finish_test();
    end
endmodule : sleep_idle_mode_controller_test

`default_nettype wire
